// >>> common/bmxc_pkg.sv
/*
  Bus matrix configuration package: register offsets, field positions,
  reset values, mode and state types, carrier structs.
  Assumes a 32-bit plain register port and a single 200 MHz clock.
*/
`default_nettype none
package bmxc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CFG    = 4'h0;
  localparam logic [3:0] OFF_STAT   = 4'h4;
  localparam logic [3:0] OFF_MASK   = 4'h8;
  localparam logic [3:0] OFF_ACTIVE = 4'hc;

  localparam int unsigned POS_ERR_SHARED = 20;
  localparam int unsigned POS_ERR_DEBUG  = 19;
  localparam int unsigned POS_ERR_DMA    = 18;
  localparam int unsigned POS_ERR_CDATA  = 17;
  localparam int unsigned POS_ERR_CINSTR = 16;
  localparam int unsigned POS_WAIT       = 6;
  localparam int unsigned POS_ARB_LO     = 0;

  localparam logic [31:0] CFG_RST      = 32'h001f_0041;
  localparam logic [31:0] CFG_WR_MASK  = 32'h001f_0047;
  localparam logic [4:0]  IRQ_MASK_RST = 5'h00;
  localparam logic [1:0]  WAIT_CYCLES  = 2'h1;

  // Initiator index order, also status and mask bit order
  localparam int unsigned N_INIT    = 5;
  localparam int unsigned IDX_CINSTR = 0;
  localparam int unsigned IDX_CDATA  = 1;
  localparam int unsigned IDX_DMA    = 2;
  localparam int unsigned IDX_DEBUG  = 3;
  localparam int unsigned IDX_SHARED = 4;

  typedef enum logic [2:0] {
    BMXC_ARB_MODE0 = 3'h0,
    BMXC_ARB_MODE1 = 3'h1,
    BMXC_ARB_MODE2 = 3'h2
  } bmxc_arb_t;

  typedef enum logic [1:0] {
    BMXC_IDLE  = 2'h0,
    BMXC_SETUP = 2'h1,
    BMXC_XFER  = 2'h3
  } bmxc_xfer_st_t;

  typedef struct packed {
    logic       err_en_shared_bus;
    logic       err_en_debug_unit;
    logic       err_en_dma_initiator;
    logic       err_en_cpu_data;
    logic       err_en_cpu_instruction;
    logic       data_ram_wait_state;
    logic [2:0] arbitration_mode_select;
  } bmxc_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } bmxc_req_t;
endpackage : bmxc_pkg
`default_nettype wire

// >>> hw/bmxc_err_gate.sv
/*
  Bus error gate: per-initiator unmapped access qualification.
  Assumes unmapped strobes are one-cycle pulses from the address decoder.
*/
`default_nettype none
module bmxc_err_gate #(
  parameter int unsigned N = 5
) (
  input  wire logic [N-1:0] unmapped,
  input  wire logic [N-1:0] enable,
  input  wire logic         debug_mode,
  output logic      [N-1:0] bus_error
);
  // Index decode below assumes the package's initiator order
  if (N != bmxc_pkg::N_INIT) begin : g_bad_n
    $error("bmxc_err_gate: N must match the initiator count");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_init
      // CPU fetch and data are silenced while debugging
      if (g == bmxc_pkg::IDX_CINSTR || g == bmxc_pkg::IDX_CDATA) begin : g_cpu
        assign bus_error[g] = unmapped[g] & enable[g] & ~debug_mode;
      end else begin : g_other
        assign bus_error[g] = unmapped[g] & enable[g];
      end
    end
  endgenerate
endmodule : bmxc_err_gate
`default_nettype wire

// >>> hw/bmxc_wait_ctl.sv
/*
  Data RAM wait-state sequencer for CPU accesses.
  Assumes a request is held until its grant; setting captured at start.
*/
`default_nettype none
module bmxc_wait_ctl (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic req,
  input  wire logic wait_en,
  output logic      grant,
  output logic      busy
);
  typedef struct packed {
    bmxc_pkg::bmxc_xfer_st_t st;
  } bmxc_wst_t;

  bmxc_wst_t s_q;
  bmxc_wst_t s_d;

  always_comb begin
    s_d = s_q;
    grant = 1'b0;
    case (s_q.st)
      bmxc_pkg::BMXC_IDLE: begin
        if (req) begin
          if (wait_en) begin
            s_d.st = bmxc_pkg::BMXC_SETUP;
          end else begin
            grant = 1'b1;
          end
        end
      end
      bmxc_pkg::BMXC_SETUP: begin
        // Setting sampled at start, so a late write cannot stretch this one
        s_d.st = bmxc_pkg::BMXC_XFER;
      end
      bmxc_pkg::BMXC_XFER: begin
        grant = 1'b1;
        s_d.st = bmxc_pkg::BMXC_IDLE;
      end
      default: s_d.st = bmxc_pkg::BMXC_IDLE;
    endcase
  end

  assign busy = (s_q.st != bmxc_pkg::BMXC_IDLE);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q.st <= bmxc_pkg::BMXC_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == bmxc_pkg::BMXC_IDLE && req && wait_en)
      |=> !grant ##1 grant)
    else $error("wait state not exactly one cycle");
  AST_NO_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == bmxc_pkg::BMXC_IDLE && req && !wait_en) |-> grant)
    else $error("zero wait access not granted at once");
endmodule : bmxc_wait_ctl
`default_nettype wire

// >>> hw/bmxc_top.sv
/*
  Bus matrix configuration: one config register, error gating per
  initiator, data RAM wait state, arbitration mode, error interrupt.
  Assumes a plain register port with read data one cycle after strobe,
  and initiator strobes synchronous to clk_sys.
*/
// Implementation choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
module bmxc_top (
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  input  wire logic [bmxc_pkg::ADDR_W-1:0]       reg_addr,
  input  wire logic [31:0]                       reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [31:0]                       reg_rdata,
  input  wire logic [bmxc_pkg::N_INIT-1:0]       unmapped_access,
  input  wire logic                              cpu_debug_mode,
  input  wire logic                              cpu_ram_req,
  output logic                                   cpu_ram_grant,
  input  wire logic                              xfer_start,
  output logic      [bmxc_pkg::N_INIT-1:0]       bus_error,
  output logic      [2:0]                        arb_mode,
  output logic                                   irq
);
  bmxc_pkg::bmxc_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  typedef struct packed {
    logic [31:0]                 cfg;
    logic [2:0]                  arb_live;
    logic                        wait_live;
    logic [bmxc_pkg::N_INIT-1:0] stat;
    logic [bmxc_pkg::N_INIT-1:0] mask;
    logic [31:0]                 rdata;
  } bmxc_state_t;

  bmxc_state_t s_q;
  bmxc_state_t s_d;
  bmxc_pkg::bmxc_cfg_t cfg_view;
  logic [bmxc_pkg::N_INIT-1:0] err_en;
  logic                        wait_busy;

  assign cfg_view = '{
    err_en_shared_bus:       s_q.cfg[bmxc_pkg::POS_ERR_SHARED],
    err_en_debug_unit:       s_q.cfg[bmxc_pkg::POS_ERR_DEBUG],
    err_en_dma_initiator:    s_q.cfg[bmxc_pkg::POS_ERR_DMA],
    err_en_cpu_data:         s_q.cfg[bmxc_pkg::POS_ERR_CDATA],
    err_en_cpu_instruction:  s_q.cfg[bmxc_pkg::POS_ERR_CINSTR],
    data_ram_wait_state:     s_q.cfg[bmxc_pkg::POS_WAIT],
    arbitration_mode_select: s_q.cfg[bmxc_pkg::POS_ARB_LO +: 3]
  };

  assign err_en = {cfg_view.err_en_shared_bus,
                   cfg_view.err_en_debug_unit,
                   cfg_view.err_en_dma_initiator,
                   cfg_view.err_en_cpu_data,
                   cfg_view.err_en_cpu_instruction};

  bmxc_err_gate #(
    .N (bmxc_pkg::N_INIT)
  ) u_gate (
    .unmapped   (unmapped_access),
    .enable     (err_en),
    .debug_mode (cpu_debug_mode),
    .bus_error  (bus_error)
  );

  bmxc_wait_ctl u_wait (
    .clk_sys (clk_sys),
    .reset   (reset),
    .req     (cpu_ram_req),
    .wait_en (s_q.wait_live),
    .grant   (cpu_ram_grant),
    .busy    (wait_busy)
  );

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    if (req.wr) begin
      case (req.addr)
        bmxc_pkg::OFF_CFG: begin
          // Reserved modes are software's duty; stored as written
          s_d.cfg = req.wdata & bmxc_pkg::CFG_WR_MASK;
        end
        bmxc_pkg::OFF_MASK: s_d.mask = req.wdata[bmxc_pkg::N_INIT-1:0];
        default: s_d.cfg = s_q.cfg;
      endcase
    end
    // Settings move to the live copy only between transfers
    if (xfer_start && !wait_busy) begin
      s_d.arb_live  = cfg_view.arbitration_mode_select;
      s_d.wait_live = cfg_view.data_ram_wait_state;
    end
    if (req.rd) begin
      case (req.addr)
        bmxc_pkg::OFF_CFG:  s_d.rdata = s_q.cfg & bmxc_pkg::CFG_WR_MASK;
        bmxc_pkg::OFF_STAT: s_d.rdata = {27'h0, s_q.stat};
        bmxc_pkg::OFF_MASK: s_d.rdata = {27'h0, s_q.mask};
        bmxc_pkg::OFF_ACTIVE: s_d.rdata = {28'h0, s_q.wait_live,
                                           s_q.arb_live};
        default: s_d.rdata = 32'h0000_0000;
      endcase
      if (req.addr == bmxc_pkg::OFF_STAT) begin
        s_d.stat = '0;
      end
    end
    // Set wins over the read-clear
    s_d.stat = s_d.stat | bus_error;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q.cfg       <= bmxc_pkg::CFG_RST;
      s_q.arb_live  <= bmxc_pkg::CFG_RST[2:0];
      s_q.wait_live <= bmxc_pkg::CFG_RST[bmxc_pkg::POS_WAIT];
      s_q.stat      <= '0;
      s_q.mask      <= bmxc_pkg::IRQ_MASK_RST;
      s_q.rdata     <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign arb_mode  = s_q.arb_live;
  assign irq       = |(s_q.stat & s_q.mask);

  // Per-initiator gating against the stored enable bits
  AST_SHARED_ERR: assert property (
    @(posedge clk_sys) disable iff (reset)
    unmapped_access[bmxc_pkg::IDX_SHARED] |->
      bus_error[bmxc_pkg::IDX_SHARED] ==
      s_q.cfg[bmxc_pkg::POS_ERR_SHARED])
    else $error("shared bus error gating wrong");

  AST_DEBUG_ERR: assert property (
    @(posedge clk_sys) disable iff (reset)
    unmapped_access[bmxc_pkg::IDX_DEBUG] |->
      bus_error[bmxc_pkg::IDX_DEBUG] ==
      s_q.cfg[bmxc_pkg::POS_ERR_DEBUG])
    else $error("debug unit error gating wrong");

  AST_DMA_ERR: assert property (
    @(posedge clk_sys) disable iff (reset)
    unmapped_access[bmxc_pkg::IDX_DMA] |->
      bus_error[bmxc_pkg::IDX_DMA] ==
      s_q.cfg[bmxc_pkg::POS_ERR_DMA])
    else $error("dma error gating wrong");

  AST_CDATA_ERR: assert property (
    @(posedge clk_sys) disable iff (reset)
    (unmapped_access[bmxc_pkg::IDX_CDATA] && !cpu_debug_mode) |->
      bus_error[bmxc_pkg::IDX_CDATA] ==
      s_q.cfg[bmxc_pkg::POS_ERR_CDATA])
    else $error("cpu data error gating wrong");

  AST_CINSTR_ERR: assert property (
    @(posedge clk_sys) disable iff (reset)
    (unmapped_access[bmxc_pkg::IDX_CINSTR] && !cpu_debug_mode) |->
      bus_error[bmxc_pkg::IDX_CINSTR] ==
      s_q.cfg[bmxc_pkg::POS_ERR_CINSTR])
    else $error("cpu fetch error gating wrong");

  AST_DEBUG_QUIET: assert property (
    @(posedge clk_sys) disable iff (reset)
    cpu_debug_mode |-> bus_error[1:0] == 2'h0)
    else $error("cpu error raised in debug mode");

  // Debug mode must not reach the non-CPU initiators
  AST_DEBUG_OTHERS: assert property (
    @(posedge clk_sys) disable iff (reset)
    cpu_debug_mode |->
      bus_error[4:2] == (unmapped_access[4:2] &
                         s_q.cfg[bmxc_pkg::POS_ERR_SHARED -: 3]))
    else $error("debug mode touched other initiators");

  AST_ERR_NEEDS_ACCESS: assert property (
    @(posedge clk_sys) disable iff (reset)
    (bus_error & ~unmapped_access) == 5'h00)
    else $error("bus error without unmapped access");

  // Sticky status, read-clear and interrupt level
  AST_STAT_SET: assert property (
    @(posedge clk_sys) disable iff (reset)
    bus_error != 5'h00 |=>
      (s_q.stat & $past(bus_error)) == $past(bus_error))
    else $error("status bit not set by bus error");

  AST_STAT_STICKY: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_rd && reg_addr == bmxc_pkg::OFF_STAT) |=>
      (s_q.stat & $past(s_q.stat)) == $past(s_q.stat))
    else $error("status bit lost without a read");

  // Set wins: an error in the read cycle survives the clear
  AST_STAT_CLEAR: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_STAT) |=>
      s_q.stat == $past(bus_error))
    else $error("status read did not clear or lost a new error");

  AST_STAT_READ: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_STAT) |=>
      reg_rdata == {27'h0, $past(s_q.stat)})
    else $error("status read data wrong");

  AST_IRQ_SET: assert property (
    @(posedge clk_sys) disable iff (reset)
    ((bus_error & s_q.mask) != 5'h00 &&
     !(reg_wr && reg_addr == bmxc_pkg::OFF_MASK)) |=> irq)
    else $error("unmasked bus error raised no interrupt");

  AST_IRQ_CLEAR: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_STAT &&
     bus_error == 5'h00) |=> !irq)
    else $error("interrupt stayed high after status read");

  AST_MASK_WRITE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_wr && reg_addr == bmxc_pkg::OFF_MASK) |=>
      s_q.mask == $past(reg_wdata[bmxc_pkg::N_INIT-1:0]))
    else $error("mask write not stored");

  AST_MASK_KEEP: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_wr && reg_addr == bmxc_pkg::OFF_MASK) |=> $stable(s_q.mask))
    else $error("mask changed without a mask write");

  AST_MASK_READ: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_MASK) |=>
      reg_rdata == {27'h0, $past(s_q.mask)})
    else $error("mask read data wrong");

  // Configuration register and read port
  AST_CFG_WRITE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_wr && reg_addr == bmxc_pkg::OFF_CFG) |=>
      s_q.cfg == ($past(reg_wdata) & bmxc_pkg::CFG_WR_MASK))
    else $error("config write not stored as masked");

  AST_CFG_KEEP: assert property (
    @(posedge clk_sys) disable iff (reset)
    !(reg_wr && reg_addr == bmxc_pkg::OFF_CFG) |=> $stable(s_q.cfg))
    else $error("config changed without a config write");

  AST_CFG_CLEAN: assert property (
    @(posedge clk_sys) disable iff (reset)
    (s_q.cfg & ~bmxc_pkg::CFG_WR_MASK) == 32'h0000_0000)
    else $error("unimplemented config bit stored");

  AST_RSVD_ZERO: assert property (
    @(posedge clk_sys) disable iff (reset)
    ($past(req.rd) && $past(req.addr) == bmxc_pkg::OFF_CFG) |->
      (reg_rdata & ~bmxc_pkg::CFG_WR_MASK) == 32'h0000_0000)
    else $error("unimplemented bits read nonzero");

  AST_CFG_READ: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_CFG) |=>
      reg_rdata == $past(s_q.cfg))
    else $error("config read data wrong");

  AST_RDATA_IDLE: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr != bmxc_pkg::OFF_CFG &&
     reg_addr != bmxc_pkg::OFF_STAT &&
     reg_addr != bmxc_pkg::OFF_MASK &&
     reg_addr != bmxc_pkg::OFF_ACTIVE) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped offset read nonzero");

  // Live copies move only at a transfer start while idle
  AST_ARB_HOLD: assert property (
    @(posedge clk_sys) disable iff (reset)
    !$past(xfer_start) |-> $stable(arb_mode))
    else $error("arbitration mode changed mid transfer");

  AST_ARB_TAKE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (xfer_start && !wait_busy) |=>
      arb_mode == $past(s_q.cfg[2:0]))
    else $error("arbitration mode not taken at transfer start");

  AST_WAIT_TAKE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (xfer_start && !wait_busy) |=>
      s_q.wait_live == $past(s_q.cfg[bmxc_pkg::POS_WAIT]))
    else $error("wait bit not taken at transfer start");

  AST_WAIT_HOLD: assert property (
    @(posedge clk_sys) disable iff (reset)
    !$past(xfer_start) |-> $stable(s_q.wait_live))
    else $error("wait bit changed outside a transfer start");

  AST_BUSY_ARB: assert property (
    @(posedge clk_sys) disable iff (reset)
    wait_busy |=> $stable(arb_mode))
    else $error("arbitration mode changed during an access");

  AST_BUSY_WAIT: assert property (
    @(posedge clk_sys) disable iff (reset)
    wait_busy |=> $stable(s_q.wait_live))
    else $error("wait bit changed during an access");

  AST_ACTIVE_READ: assert property (
    @(posedge clk_sys) disable iff (reset)
    (reg_rd && reg_addr == bmxc_pkg::OFF_ACTIVE) |=>
      reg_rdata == {28'h0, $past(s_q.wait_live), $past(arb_mode)})
    else $error("active settings read data wrong");

  // Wait length seen from the top, with the live bit frozen
  AST_WAIT_GATE: assert property (
    @(posedge clk_sys) disable iff (reset)
    (cpu_ram_req && !wait_busy && s_q.wait_live) |-> !cpu_ram_grant)
    else $error("grant given without the setup cycle");

  AST_WAIT_LEN: assert property (
    @(posedge clk_sys) disable iff (reset)
    (cpu_ram_req && !wait_busy && s_q.wait_live) |=>
      (wait_busy && !cpu_ram_grant) ##1 cpu_ram_grant)
    else $error("waited access not granted after one setup cycle");
endmodule : bmxc_top
`default_nettype wire

// >>> sim/bmxc_cpu_model.sv
/*
  CPU data RAM requester standing at the far side of the wait sequencer.
  Assumes grant is sampled on the rising edge of clk_sys.
*/
`default_nettype none
module bmxc_cpu_model (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic go,
  input  wire logic grant,
  output var logic  req,
  output var logic  done,
  output var int    lat
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Request held until grant is seen at an edge
  always @(posedge clk_sys) begin
    done <= 1'b0;
    if (reset) begin
      req <= 1'b0;
      cnt <= 0;
    end else if (go && !req) begin
      req <= 1'b1;
      cnt <= 0;
    end else if (req && grant) begin
      req  <= 1'b0;
      done <= 1'b1;
      lat  <= cnt;
    end else if (req) begin
      cnt <= cnt + 1;
    end
  end
endmodule : bmxc_cpu_model
`default_nettype wire

// >>> sim/test_bus_matrix_config.sv
/*
  Self-checking bench: register port, error gating, interrupt, wait state
  and live arbitration mode.
  Assumes bmxc_pkg and bmxc_cpu_model are compiled first.
*/
`default_nettype none
module test_bus_matrix_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [4:0]  unmapped_access = 5'h00, bus_error;
  logic cpu_debug_mode = 1'b0, xfer_start = 1'b0, go = 1'b0;
  logic cpu_ram_req, cpu_ram_grant, irq, done;
  logic [2:0]  arb_mode;
  int miscompares = 0, n_compared = 0, cycles = 0, lat;

  bmxc_top i_bmxc_top (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .unmapped_access(unmapped_access), .cpu_debug_mode(cpu_debug_mode),
    .cpu_ram_req(cpu_ram_req), .cpu_ram_grant(cpu_ram_grant),
    .xfer_start(xfer_start), .bus_error(bus_error), .arb_mode(arb_mode),
    .irq(irq));
  bmxc_cpu_model i_bmxc_cpu_model (.clk_sys(clk_sys), .reset(reset),
    .go(go), .grant(cpu_ram_grant), .req(cpu_ram_req), .done(done),
    .lat(lat));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Ceiling well above the hundred or so cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic err(input logic [4:0] u, input logic [4:0] e);
    @(posedge clk_sys);
    unmapped_access <= u;
    #1 chk("bus_error", {27'h0, e}, {27'h0, bus_error});
    @(posedge clk_sys);
    unmapped_access <= 5'h00;
  endtask : err

  task automatic t_regs;
    rd(bmxc_pkg::OFF_CFG);
    chk("cfg reset", 32'h001f_0041, d);
    chk("arb reset", 32'h1, {29'h0, arb_mode});
    wr(bmxc_pkg::OFF_CFG, 32'hffff_ffba);
    rd(bmxc_pkg::OFF_CFG);
    chk("cfg ones", 32'h001f_0002, d);
    rd(4'h2);
    chk("unmapped rd", 32'h0, d);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_errors;
    for (int i = 0; i < 5; i++) begin
      wr(bmxc_pkg::OFF_CFG, (32'h1 << (16 + i)) | 32'h41);
      err(5'h1f, 5'(1 << i));
    end
    wr(bmxc_pkg::OFF_CFG, 32'h001f_0041);
    cpu_debug_mode <= 1'b1;
    err(5'h1f, 5'h1c);
    cpu_debug_mode <= 1'b0;
    err(5'h03, 5'h03);
    $display("t_errors done");
  endtask : t_errors

  task automatic t_irq;
    rd(bmxc_pkg::OFF_STAT);
    wr(bmxc_pkg::OFF_MASK, 32'h10);
    rd(bmxc_pkg::OFF_MASK);
    chk("mask", 32'h10, d);
    err(5'h10, 5'h10);
    @(posedge clk_sys);
    #1 chk("irq set", 32'h1, {31'h0, irq});
    rd(bmxc_pkg::OFF_STAT);
    chk("status", 32'h10, d);
    rd(bmxc_pkg::OFF_STAT);
    chk("status clr", 32'h0, d);
    chk("irq clr", 32'h0, {31'h0, irq});
    err(5'h04, 5'h04);
    @(posedge clk_sys);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    $display("t_irq done");
  endtask : t_irq

  // Mode and wait bit only go live at a transfer start
  task automatic t_wait_arb;
    // Only the defined mode codes are ever written
    for (int m = 0; m < 3; m++) begin
      wr(bmxc_pkg::OFF_CFG, 32'h001f_0000 | (32'(m & 1) << 6) | 32'(m));
      #1 chk("arb held", 32'(m == 0 ? 1 : m - 1), {29'h0, arb_mode});
      @(posedge clk_sys);
      xfer_start <= 1'b1;
      @(posedge clk_sys);
      xfer_start <= 1'b0;
      #1 chk("arb live", 32'(m), {29'h0, arb_mode});
      rd(bmxc_pkg::OFF_ACTIVE);
      chk("active", 32'(((m & 1) << 3) | m), d);
      @(posedge clk_sys);
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      for (int k = 0; k < 10 && done !== 1'b1; k++) @(posedge clk_sys) #1;
      chk("grant done", 32'h1, {31'h0, done});
      chk("wait lat", (m & 1) ? 32'h2 : 32'h0, 32'(lat));
    end
    $display("t_wait_arb done");
  endtask : t_wait_arb

  task automatic finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_errors();
    t_irq();
    t_wait_arb();
    finish_test();
  end
endmodule : test_bus_matrix_config
`default_nettype wire
